// ---- bench/cpu_reset_irq_halt_control_tb.sv ----
module cpu_reset_irq_halt_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 0, srst_i = 1, reset_pin_i = 0, mode_strap_i = 0, nmi_pin_i = 0;
  logic test_n_i = 1, hold_req_i = 0, instr_boundary_i = 0, halt_instr_i = 0;
  logic lock_prefix_i = 0, lock_instr_done_i = 0, wait_instr_i = 0, queue_full_i = 0;
  logic flags_pushed_i = 0, set_ie_i = 0, clr_ie_i = 0, raise = 0;
  logic [7:0] ptype = 8'h00;
  wire maskable_irq_request_i;
  wire [7:0] data_bus_i;
  wire cpu_active_o, fetch_start_o, irq_take_o, ie_flag_o, halted_o, wait_done_o;
  wire wait_bus_idle_o, irq_acknowledge_strobe_n_o, status_line_zero_n_o, ale_o;
  wire lock_n_o, hold_ack_o, request_grant_port_o;
  wire [19:0] fetch_addr_o, vector_addr_o;
  wire [2:0] cycle_status_code_o;
  int mismatches = 0, n_tests = 0;
  always #5 clock_i = ~clock_i;
  crihc_top crihc_top_inst (.clock_i, .srst_i, .reset_pin_i, .mode_strap_i, .nmi_pin_i,
    .maskable_irq_request_i, .test_n_i, .hold_req_i, .instr_boundary_i, .halt_instr_i,
    .lock_prefix_i, .lock_instr_done_i, .wait_instr_i, .queue_full_i, .flags_pushed_i,
    .set_ie_i, .clr_ie_i, .data_bus_i, .cpu_active_o, .fetch_start_o, .fetch_addr_o,
    .irq_take_o, .vector_addr_o, .ie_flag_o, .halted_o, .wait_done_o, .wait_bus_idle_o,
    .irq_acknowledge_strobe_n_o, .cycle_status_code_o, .status_line_zero_n_o, .ale_o,
    .lock_n_o, .hold_ack_o, .request_grant_port_o);
  crihc_pic_model crihc_pic_model_inst (.clock_i, .strobe_n_i(irq_acknowledge_strobe_n_o),
    .raise_i(raise), .type_i(ptype), .irq_o(maskable_irq_request_i), .data_o(data_bus_i));
  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic take_wait;
    int i;
    for (i = 0; i < 30 && irq_take_o !== 1'b1; i++) step(1);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset(input bit pin);
    int i;
    if (pin) reset_pin_i = 1;
    else srst_i = 1;
    step(pin ? 5 : 2);
    chk(20'(cpu_active_o), 20'h0);
    srst_i = 0;
    reset_pin_i = 0;
    for (i = 0; i < 20 && fetch_start_o !== 1'b1; i++) step(1);
    chk(fetch_addr_o, 20'hFFFF0);
    chk(20'(i >= 6), 20'h1);
  endtask
  task automatic t_irq;
    int i, falls;
    logic s;
    set_ie_i = 1;
    step(1);
    set_ie_i = 0;
    chk(20'(ie_flag_o), 20'h1);
    ptype = 8'hA7;
    raise = 1;
    step(3);
    instr_boundary_i = 1;
    step(1);
    instr_boundary_i = 0;
    falls = 0;
    s = 1'b1;
    for (i = 0; i < 30 && irq_take_o !== 1'b1; i++) begin
      if (s && !irq_acknowledge_strobe_n_o) falls++;
      s = irq_acknowledge_strobe_n_o;
      step(1);
    end
    raise = 0;
    chk(vector_addr_o, {10'h000, ptype, 2'h0});
    chk(20'(falls), 20'h2);
    flags_pushed_i = 1;
    step(1);
    flags_pushed_i = 0;
    chk(20'(ie_flag_o), 20'h0);
  endtask
  task automatic t_masked;
    int i;
    logic seen;
    seen = 1'b0;
    raise = 1;
    step(3);
    instr_boundary_i = 1;
    step(1);
    instr_boundary_i = 0;
    for (i = 0; i < 20; i++) begin
      seen |= irq_take_o;
      step(1);
    end
    raise = 0;
    chk(20'(seen), 20'h0);
  endtask
  task automatic t_nmi;
    set_ie_i = 1;
    raise = 1;
    nmi_pin_i = 1;
    step(4);
    set_ie_i = 0;
    nmi_pin_i = 0;
    instr_boundary_i = 1;
    step(1);
    instr_boundary_i = 0;
    take_wait();
    raise = 0;
    chk(vector_addr_o, 20'h00008);
    flags_pushed_i = 1;
    step(1);
    flags_pushed_i = 0;
    step(12);
  endtask
  task automatic t_halt;
    int i;
    halt_instr_i = 1;
    step(1);
    halt_instr_i = 0;
    chk(20'(ale_o), 20'h0);
    step(1);
    chk(20'(ale_o), 20'h1);
    step(2);
    chk(20'(halted_o), 20'h1);
    chk(20'(cycle_status_code_o), 20'h3);
    hold_req_i = 1;
    step(6);
    hold_req_i = 0;
    for (i = 0; i < 10 && ale_o !== 1'b1; i++) step(1);
    chk(20'(ale_o), 20'h1);
    chk(20'(halted_o), 20'h1);
    chk(20'(cycle_status_code_o), 20'h3);
    nmi_pin_i = 1;
    step(4);
    nmi_pin_i = 0;
    for (i = 0; i < 20 && halted_o !== 1'b0; i++) step(1);
    chk(20'(halted_o), 20'h0);
    take_wait();
    chk(vector_addr_o, 20'h00008);
    flags_pushed_i = 1;
    step(1);
    flags_pushed_i = 0;
    step(15);
  endtask
  task automatic t_min_halt;
    halt_instr_i = 1;
    step(1);
    halt_instr_i = 0;
    step(3);
    chk(20'({halted_o, status_line_zero_n_o}), 20'h2);
    set_ie_i = 1;
    raise = 1;
    step(1);
    set_ie_i = 0;
    take_wait();
    raise = 0;
    chk(20'({halted_o, lock_n_o}), 20'h1);
    chk(vector_addr_o, {10'h000, ptype, 2'h0});
    flags_pushed_i = 1;
    step(1);
    flags_pushed_i = 0;
  endtask
  task automatic t_lock;
    int i;
    lock_prefix_i = 1;
    step(1);
    lock_prefix_i = 0;
    step(1);
    chk(20'(lock_n_o), 20'h0);
    hold_req_i = 1;
    step(4);
    chk(20'(hold_ack_o), 20'h0);
    lock_instr_done_i = 1;
    step(1);
    lock_instr_done_i = 0;
    chk(20'(request_grant_port_o), 20'h1);
    for (i = 0; i < 10 && hold_ack_o !== 1'b1; i++) step(1);
    chk(20'({lock_n_o, hold_ack_o}), 20'h3);
    hold_req_i = 0;
    step(4);
  endtask
  task automatic t_wait;
    wait_instr_i = 1;
    queue_full_i = 1;
    step(4);
    chk(20'({wait_done_o, wait_bus_idle_o}), 20'h1);
    test_n_i = 0;
    step(5);
    chk(20'(wait_done_o), 20'h1);
    wait_instr_i = 0;
    queue_full_i = 0;
    test_n_i = 1;
    step(2);
  endtask
  initial begin
    t_reset(1'b0);
    t_irq();
    t_masked();
    t_nmi();
    t_halt();
    t_lock();
    t_wait();
    t_reset(1'b0);
    mode_strap_i = 1;
    t_reset(1'b1);
    t_min_halt();
    tally_and_finish();
  end
  initial begin
    #20000;
    mismatches++;
    tally_and_finish();
  end
endmodule

// ---- bench/crihc_pic_model.sv ----
// ****************************************
// Interrupt controller and requester model
// ****************************************
module crihc_pic_model (
  input wire clock_i,
  input wire strobe_n_i,
  input wire raise_i,
  input wire [7:0] type_i,
  output logic irq_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic s_q;
  int n;
  initial begin
    irq_o = 1'b0;
    s_q = 1'b1;
    n = 0;
  end
  always @(posedge clock_i) begin
    s_q <= strobe_n_i;
    if (s_q && !strobe_n_i) begin
      n <= n + 1;
      irq_o <= 1'b0;
    end else if (!raise_i) begin
      irq_o <= 1'b0;
      n <= 0;
    end else if (n == 0) begin
      irq_o <= 1'b1;
    end
  end
  // Type byte from the second acknowledge until the request drops, scrambled before that
  assign data_o = (n == 2) ? type_i : ~type_i;
endmodule

// ---- bench/crihc_top_asserts.sv ----
module crihc_top_asserts (
  input wire clock_i,
  input wire srst_i,
  input wire fetch_start_o,
  input wire [19:0] fetch_addr_o,
  input wire irq_take_o,
  input wire [19:0] vector_addr_o,
  input wire ie_flag_o,
  input wire halted_o,
  input wire cpu_active_o,
  input wire flags_pushed_i,
  input wire set_ie_i,
  input wire irq_acknowledge_strobe_n_o,
  input wire [2:0] cycle_status_code_o,
  input wire hold_ack_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  AST_RESET_IDLE: assert property (@(posedge clock_i) disable iff (1'b0)
    srst_i ##1 srst_i |-> !cpu_active_o && irq_acknowledge_strobe_n_o && !hold_ack_o)
    else $error("outputs not idle in reset");
  AST_INIT_DELAY: assert property ($fell(srst_i) |->
    !fetch_start_o [*6] ##[1:8] fetch_start_o) else $error("fetch start timing");
  AST_FETCH_ADDR: assert property (fetch_start_o |-> fetch_addr_o == 20'hFFFF0)
    else $error("wrong start address");
  AST_VEC_TABLE: assert property (irq_take_o |->
    vector_addr_o[19:10] == 10'h000 && vector_addr_o[1:0] == 2'h0)
    else $error("vector outside table");
  AST_STROBE_TWO: assert property ($fell(irq_acknowledge_strobe_n_o) |=>
    !irq_acknowledge_strobe_n_o ##1 irq_acknowledge_strobe_n_o)
    else $error("strobe width");
  AST_NO_HOLD_ACK: assert property (!irq_acknowledge_strobe_n_o |-> !hold_ack_o)
    else $error("hold granted in acknowledge");
  AST_IE_CLEAR: assert property (flags_pushed_i && !set_ie_i |=> !ie_flag_o)
    else $error("enable flag not cleared");
  AST_HALT_CODE: assert property ($rose(halted_o) |->
    ##[0:3] cycle_status_code_o == 3'h3) else $error("no halt status");
  COV_TAKE: cover property (irq_take_o);
  COV_HALT: cover property ($rose(halted_o));
  COV_START: cover property (fetch_start_o);
endmodule
bind crihc_top crihc_top_asserts crihc_top_asserts_inst (.clock_i, .srst_i,
  .fetch_start_o, .fetch_addr_o, .irq_take_o, .vector_addr_o, .ie_flag_o, .halted_o,
  .cpu_active_o, .flags_pushed_i, .set_ie_i, .irq_acknowledge_strobe_n_o,
  .cycle_status_code_o, .hold_ack_o);

// ---- rtl/crihc_consts.vh ----
`ifndef CRIHC_CONSTS_VH
`define CRIHC_CONSTS_VH

// Reset and start-up
`define CRIHC_INIT_CLKS 4'h7
`define CRIHC_NMI_BLIND_CLKS 2'h2
`define CRIHC_RESET_ADDR 20'hFFFF0

// Interrupt vectors
`define CRIHC_NMI_TYPE 8'h02
`define CRIHC_VEC_SHIFT 2

// Cycle status codes, active-low encoding on the status pins
`define CRIHC_ST_IRQ_ACKNOWLEDGE_STROBE 3'h0
`define CRIHC_ST_HALT 3'h3
`define CRIHC_ST_PASSIVE 3'h7

// Acknowledge bus cycle phases (T1..T4)
`define CRIHC_T_LAST 2'h3
`define CRIHC_T2 2'h1

`endif

// ---- rtl/crihc_sync.v ----
// ****************************************
// Two-stage synchroniser
// ****************************************
module crihc_sync (
  input wire clock_i,
  input wire srst_i,
  input wire d_i,
  output wire q_o
);
  reg s1_q;
  reg s2_q;

  always @(posedge clock_i) begin
    if (srst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end

  assign q_o = s2_q;
endmodule

// ---- rtl/crihc_top.v ----
// Functional notes
// (RULE1) Reset source holds reset over four clocks
// (RULE2) Reset high aborts everything, stays dormant
// (RULE3) Seven-clock init, then fetch from FFFF0
// (RULE4) Reset input synchronised to processor clock
// (RULE5) Power-up reset released after 50 us
// (RULE6) Ignore NMI before second clock after reset
// (RULE7) Vector table: 256 four-byte entries at zero
// (RULE8) NMI rising edge, top priority, type 2
// (RULE9) NMI source holds high over two clocks
// (RULE10) NMI edge latched, serviced at boundary
// (RULE11) Maskable request level, gated by enable flag
// (RULE12) Maskable request high before instruction end
// (RULE13) Requester may drop after first acknowledge
// (RULE14) Response clears enable flag after flags pushed
// (RULE15) Two acknowledge cycles, lock T2 to T2
// (RULE16) Bus hold deferred until acknowledges done
// (RULE17) Type byte times four gives vector address
// (RULE18) Halt: min delays strobe, max status code
// (RULE19) Hold while halted; reissue halt afterwards
// (RULE20) Halt left only by interrupt or reset
// (RULE21) Lock prefix: lock low, requests deferred
// (RULE22) Wait loops until sync input low
`include "crihc_consts.vh"

module crihc_top (
  // Clock and reset
  input wire clock_i,
  input wire srst_i,
  input wire reset_pin_i,
  // Strap and external requests (asynchronous pins)
  input wire mode_strap_i,
  input wire nmi_pin_i,
  input wire maskable_irq_request_i,
  input wire test_n_i,
  input wire hold_req_i,
  // Execution unit interface (same clock)
  input wire instr_boundary_i,
  input wire halt_instr_i,
  input wire lock_prefix_i,
  input wire lock_instr_done_i,
  input wire wait_instr_i,
  input wire queue_full_i,
  input wire flags_pushed_i,
  input wire set_ie_i,
  input wire clr_ie_i,
  input wire [7:0] data_bus_i,
  // Status to execution unit
  output reg cpu_active_o,
  output reg fetch_start_o,
  output reg [19:0] fetch_addr_o,
  output reg irq_take_o,
  output reg [19:0] vector_addr_o,
  output reg ie_flag_o,
  output reg halted_o,
  output reg wait_done_o,
  output wire wait_bus_idle_o,
  // Bus pins
  output reg irq_acknowledge_strobe_n_o,
  output reg [2:0] cycle_status_code_o,
  output reg status_line_zero_n_o,
  output reg ale_o,
  output reg lock_n_o,
  output reg hold_ack_o,
  output reg request_grant_port_o
);

  // ****************************************
  // Synchronisers
  // ****************************************
  wire rst_s;
  wire nmi_s;
  wire irq_s;
  wire test_s;
  wire hold_s;
  wire [4:0] pin_raw = {hold_req_i, test_n_i, maskable_irq_request_i, nmi_pin_i, reset_pin_i};
  wire [4:0] pin_s;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      crihc_sync u_sync (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .d_i(pin_raw[gi]),
        .q_o(pin_s[gi])
      );
    end
  endgenerate
  assign rst_s = pin_s[0]; // see (RULE4)
  assign nmi_s = pin_s[1];
  assign irq_s = pin_s[2];
  assign test_s = pin_s[3];
  assign hold_s = pin_s[4];

  // ****************************************
  // Reset sequencing
  // ****************************************
  localparam RS_DORMANT = 2'h0;
  localparam RS_INIT = 2'h1;
  localparam RS_RUN = 2'h2;

  reg [1:0] rs_q;
  reg [3:0] init_cnt_q;
  reg [1:0] blind_q;
  reg mode_max_q;
  wire in_reset = srst_i | rst_s;

  always @(posedge clock_i) begin
    if (in_reset) begin
      rs_q <= RS_DORMANT; // see (RULE2)
      init_cnt_q <= 4'h0;
      blind_q <= 2'h0;
      cpu_active_o <= 1'b0;
      fetch_start_o <= 1'b0;
      fetch_addr_o <= 20'h00000;
    end else begin
      fetch_start_o <= 1'b0;
      case (rs_q)
        RS_DORMANT: begin
          rs_q <= RS_INIT;
          init_cnt_q <= 4'h1;
          mode_max_q <= ~mode_strap_i;
        end
        RS_INIT: begin
          if (init_cnt_q == `CRIHC_INIT_CLKS) begin
            rs_q <= RS_RUN; // see (RULE3)
            cpu_active_o <= 1'b1;
            fetch_start_o <= 1'b1;
            fetch_addr_o <= `CRIHC_RESET_ADDR;
          end else begin
            init_cnt_q <= init_cnt_q + 4'h1;
          end
        end
        RS_RUN: begin
          cpu_active_o <= 1'b1;
        end
        default: rs_q <= RS_DORMANT;
      endcase
      if (blind_q != `CRIHC_NMI_BLIND_CLKS) begin
        blind_q <= blind_q + 2'h1;
      end
    end
  end

  // ****************************************
  // NMI edge latch
  // ****************************************
  reg nmi_prev_q;
  reg nmi_pend_q;
  wire nmi_armed = (blind_q == `CRIHC_NMI_BLIND_CLKS);
  wire nmi_rise = nmi_s & ~nmi_prev_q & nmi_armed; // see (RULE6)
  wire run = (rs_q == RS_RUN);

  // ****************************************
  // Acknowledge sequencer
  // ****************************************
  localparam AS_IDLE = 3'h0;
  localparam AS_ACK1 = 3'h1;
  localparam AS_ACK2 = 3'h2;
  localparam AS_VECT = 3'h3;
  localparam AS_PUSH = 3'h4;

  reg [2:0] as_q;
  reg [1:0] tph_q;
  reg [7:0] type_q;
  wire take_nmi = run & instr_boundary_i & nmi_pend_q & (as_q == AS_IDLE);
  wire take_irq = run & instr_boundary_i & irq_s & ie_flag_o & ~nmi_pend_q
    & (as_q == AS_IDLE) & ~hold_ack_o; // see (RULE11)
  wire halt_wake = halted_o & ((nmi_pend_q) | (irq_s & ie_flag_o)); // see (RULE20)
  wire take_any = take_nmi | take_irq
    | (halt_wake & (as_q == AS_IDLE) & ~hold_ack_o);
  wire wake_irq = halt_wake & ~nmi_pend_q;

  always @(posedge clock_i) begin
    if (in_reset) begin
      nmi_prev_q <= 1'b0;
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_s;
      // A new edge in the same cycle as service start re-arms the latch
      if (nmi_rise) begin
        nmi_pend_q <= 1'b1; // see (RULE8)
      end else if (take_nmi | (take_any & nmi_pend_q)) begin
        nmi_pend_q <= 1'b0; // see (RULE10)
      end
    end
  end

  always @(posedge clock_i) begin
    if (in_reset) begin
      as_q <= AS_IDLE;
      tph_q <= 2'h0;
      type_q <= 8'h00;
      irq_take_o <= 1'b0;
      vector_addr_o <= 20'h00000;
      ie_flag_o <= 1'b0;
      irq_acknowledge_strobe_n_o <= 1'b1;
    end else begin
      irq_take_o <= 1'b0;
      case (as_q)
        AS_IDLE: begin
          tph_q <= 2'h0;
          if (take_any) begin
            if (nmi_pend_q) begin
              type_q <= `CRIHC_NMI_TYPE; // see (RULE8)
              as_q <= AS_VECT;
            end else if (take_irq | wake_irq) begin
              as_q <= AS_ACK1; // see (RULE15)
            end
          end
        end
        AS_ACK1, AS_ACK2: begin
          tph_q <= tph_q + 2'h1;
          irq_acknowledge_strobe_n_o <= ~((tph_q == 2'h0) | (tph_q == `CRIHC_T2));
          if (tph_q == `CRIHC_T_LAST) begin
            if (as_q == AS_ACK2) begin
              type_q <= data_bus_i; // see (RULE17)
              as_q <= AS_VECT;
            end else begin
              as_q <= AS_ACK2;
            end
          end
        end
        AS_VECT: begin
          vector_addr_o <= {12'h000, type_q} << `CRIHC_VEC_SHIFT; // see (RULE7) (RULE17)
          irq_take_o <= 1'b1;
          as_q <= AS_PUSH;
        end
        AS_PUSH: begin
          if (flags_pushed_i) begin
            as_q <= AS_IDLE;
          end
        end
        default: as_q <= AS_IDLE;
      endcase
      if (as_q == AS_PUSH & flags_pushed_i) begin
        ie_flag_o <= 1'b0; // see (RULE14)
      end else if (set_ie_i) begin
        ie_flag_o <= 1'b1;
      end else if (clr_ie_i) begin
        ie_flag_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // Halt, lock and bus hold
  // ****************************************
  localparam HS_NONE = 2'h0;
  localparam HS_ALE_DLY = 2'h1;
  localparam HS_HALTED = 2'h2;

  reg [1:0] hs_q;
  reg lock_pend_q;
  reg prefix_lock_q;
  reg hold_seen_q;
  wire in_ack = (as_q == AS_ACK1) | (as_q == AS_ACK2);
  // Hold is refused during acknowledges and while the prefix lock stands
  wire hold_ok = hold_s & ~in_ack & ~prefix_lock_q & (as_q == AS_IDLE); // see (RULE16) (RULE21)

  always @(posedge clock_i) begin
    if (in_reset) begin
      hs_q <= HS_NONE;
      halted_o <= 1'b0;
      ale_o <= 1'b0;
      cycle_status_code_o <= `CRIHC_ST_PASSIVE;
      status_line_zero_n_o <= 1'b1;
      lock_pend_q <= 1'b0;
      prefix_lock_q <= 1'b0;
      hold_ack_o <= 1'b0;
      hold_seen_q <= 1'b0;
      request_grant_port_o <= 1'b0;
      wait_done_o <= 1'b0;
    end else begin
      ale_o <= 1'b0;
      request_grant_port_o <= 1'b0;
      cycle_status_code_o <= in_ack ? `CRIHC_ST_IRQ_ACKNOWLEDGE_STROBE : `CRIHC_ST_PASSIVE;
      status_line_zero_n_o <= 1'b1;
      case (hs_q)
        HS_NONE: begin
          if (run & halt_instr_i) begin
            hs_q <= HS_ALE_DLY;
          end
        end
        HS_ALE_DLY: begin
          // Strobe is one clock late so the halt status is stable when latched
          ale_o <= ~hold_ack_o; // see (RULE18)
          halted_o <= 1'b1;
          hs_q <= HS_HALTED;
        end
        HS_HALTED: begin
          if (halt_wake) begin
            halted_o <= 1'b0; // see (RULE20)
            hs_q <= HS_NONE;
          end else if (hold_seen_q & ~hold_ack_o) begin
            hs_q <= HS_ALE_DLY; // see (RULE19)
          end
        end
        default: hs_q <= HS_NONE;
      endcase
      if (hs_q != HS_NONE) begin
        cycle_status_code_o <= `CRIHC_ST_HALT; // see (RULE18)
        status_line_zero_n_o <= mode_max_q;
      end
      hold_seen_q <= hold_ack_o & (hs_q != HS_NONE);
      hold_ack_o <= hold_ok;
      if (lock_prefix_i & run) begin
        prefix_lock_q <= 1'b1; // see (RULE21)
      end else if (lock_instr_done_i) begin
        prefix_lock_q <= 1'b0;
        if (lock_pend_q | (hold_s & mode_max_q)) begin
          request_grant_port_o <= 1'b1;
        end
        lock_pend_q <= 1'b0;
      end else if (prefix_lock_q & hold_s & mode_max_q) begin
        lock_pend_q <= 1'b1;
      end
      wait_done_o <= run & wait_instr_i & ~test_s; // see (RULE22)
    end
  end

  // One driver for lock: acknowledge window and prefixed instruction share the pin
  always @(posedge clock_i) begin
    if (in_reset) begin
      lock_n_o <= 1'b1;
    end else if (mode_max_q & (as_q == AS_ACK1) & (tph_q == 2'h0)) begin
      lock_n_o <= 1'b0; // see (RULE15)
    end else if (lock_instr_done_i & prefix_lock_q) begin
      lock_n_o <= 1'b1; // see (RULE21)
    end else if (prefix_lock_q) begin
      lock_n_o <= 1'b0; // see (RULE21)
    end else if (mode_max_q & (as_q == AS_ACK2) & (tph_q == 2'h0)) begin
      lock_n_o <= 1'b1; // see (RULE15)
    end
  end

  assign wait_bus_idle_o = wait_instr_i & queue_full_i; // see (RULE22)

endmodule
